// [src/cai_pkg.sv]
// cai_pkg: opcodes, flag layout, timing and reset constants of the execution datapath
// assumes: an 8-bit core on a 10 MHz system clock, with the APB master in the test bench
package cai_pkg;
   // ----------------------------------------------------------------------
   // operation codes, as written to the op field of the command register
   // ----------------------------------------------------------------------
   typedef enum logic [4:0] {
      CAI_NOP = 5'h00,
      CAI_ADC_W = 5'h01,   // add with carry, result to working
      CAI_ADC_M = 5'h02,   // add_with_carry_to_memory
      CAI_ADD_W = 5'h03,
      CAI_ADD_X = 5'h04,   // immediate operand
      CAI_ADD_M = 5'h05,   // sum_to_memory
      CAI_AND_W = 5'h06,
      CAI_AND_X = 5'h07,
      CAI_AND_M = 5'h08,   // bitwise_conj_to_memory
      CAI_CALL = 5'h09,
      CAI_ZFILL = 5'h0A,   // zero_fill_op
      CAI_ZBIT = 5'h0B,
      CAI_KICK = 5'h0C,    // watchdog_kick
      CAI_PRE1 = 5'h0D,    // watchdog_prekick_first
      CAI_PRE2 = 5'h0E,    // watchdog_prekick_second
      CAI_INV_M = 5'h0F,   // invert_memory
      CAI_INV_W = 5'h10,   // invert_to_working
      CAI_DFIX = 5'h11,    // decimal_fixup
      CAI_DEC_M = 5'h12,   // minus_one_memory
      CAI_DEC_W = 5'h13,   // minus_one_to_working
      CAI_INC_M = 5'h14,
      CAI_INC_W = 5'h15,   // plus_one_to_working
      CAI_SLEEP = 5'h16,
      CAI_GOTO = 5'h17     // goto_op
   } cai_op_e;

   // ----------------------------------------------------------------------
   // register map
   // ----------------------------------------------------------------------
   localparam logic [7:0] CAI_A_CMD = 8'h00;    // w: op[4:0], bit[10:8], go by write
   localparam logic [7:0] CAI_A_OPND = 8'h04;   // w: mem byte [7:0], imm [15:8], tgt [27:16]
   localparam logic [7:0] CAI_A_WORK = 8'h08;   // rw: working register
   localparam logic [7:0] CAI_A_FLAG = 8'h0C;   // rw: status flags
   localparam logic [7:0] CAI_A_PC = 8'h10;     // rw: program counter
   localparam logic [7:0] CAI_A_MEMR = 8'h14;   // r: mem result [7:0], write [8], low-pc [9]
   localparam logic [7:0] CAI_A_STK = 8'h18;    // r: pushed address [11:0], push [12]
   localparam logic [7:0] CAI_A_STAT = 8'h1C;   // r: busy [0], asleep [1], prekick mask [3:2]
   localparam logic [7:0] CAI_A_WDT = 8'h20;    // r: watchdog_counter, prescaler [15:8]

   // flag bit positions
   localparam int CAI_F_C = 0;
   localparam int CAI_F_HC = 1;   // half_carry_flag
   localparam int CAI_F_Z = 2;
   localparam int CAI_F_OV = 3;   // signed_wrap_flag
   localparam int CAI_F_SL = 4;   // sleep_entered_flag
   localparam int CAI_F_TO = 5;   // watchdog_expiry_flag

   localparam logic [5:0] CAI_FLAG_RST = 6'h00;
   localparam logic [11:0] CAI_PC_RST = 12'h000;
   // one instruction cycle is four system clocks
   localparam int CAI_CYC_CLKS = 4;
   localparam logic [3:0] CAI_EXTRA_CLKS = 4'h4;
   localparam logic [7:0] CAI_DIG_LIM = 8'h09;
   localparam logic [7:0] CAI_DIG_ADJ = 8'h06;
endpackage

// [src/cai_core.sv]
// cai_core: execution semantics of the arithmetic, clear, watchdog, sleep and branch operations
// assumes: an APB master on pclk supplies operands and starts each operation
`timescale 1ns/10ps
`default_nettype none
// Behaviour
// RL1 - add with carry, all four arithmetic flags
// RL2 - plain add, memory or immediate operand
// RL3 - and sets only zero flag
// RL4 - call pushes pc plus one, loads target
// RL5 - clear byte writes zero, flags kept
// RL6 - clear bit zeroes one bit only
// RL7 - kick clears counter, sleep and expiry flags
// RL8 - prekicks clear only when both executed
// RL9 - invert byte, memory or working destination
// RL10 - low digit fixup adds six, digit carry
// RL11 - high digit fixup, only carry changes
// RL12 - decrement byte, zero flag only
// RL13 - increment byte, zero flag only
// RL14 - sleep halts execution, contents kept
// RL15 - sleep clears watchdog, sets sleep flag, pc+1
// RL16 - jump loads target, no push, flags kept
// RL17 - low pc write costs four clocks more
// RL18 - unaffected flags hold their value
// RL19 - zero flag tracks eight-bit result
module cai_core #(
   parameter int PC_W = 12
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   output logic asleep,
   output logic busy
);
   // ---------------------------------------------------------------------
   // state
   // ---------------------------------------------------------------------
   typedef struct packed {
      logic [31:0] rdata;
      logic ready;
      logic err;
      logic [7:0] mem;
      logic [7:0] imm;
      logic [11:0] tgt;
      logic [7:0] work;
      logic [5:0] flags;
      logic [11:0] pc;
      logic [7:0] mres;
      logic mwr;
      logic lowpc;
      logic [11:0] stk;
      logic push;
      logic [7:0] wdt;
      logic [7:0] pre;
      logic [1:0] pmask;
      logic slp;
      logic [3:0] wait_cnt;
      logic bsy;
   } cai_st_s;

   cai_st_s st_ff, nxt_st;

   initial begin
      if (PC_W != 12) $error("cai_core supports only a 12-bit program counter");
   end

   logic acc_w, acc_r;
   logic [8:0] sum;
   logic [4:0] lsum;
   logic [7:0] opb, res;
   logic cin, ov, lo_fix, dc, hi_fix;
   logic [4:0] hi_n;
   logic [3:0] lo_n;

   assign acc_w = psel && penable && pwrite && !st_ff.ready;
   assign acc_r = psel && penable && !pwrite && !st_ff.ready;

   // ---------------------------------------------------------------------
   // adder shared by the add family
   // ---------------------------------------------------------------------
   always_comb begin
      // operand choice follows the command being written, not the last one run
      opb = (pwdata[4:0] == cai_pkg::CAI_ADD_X) ? st_ff.imm : st_ff.mem;
      cin = (pwdata[4:0] == cai_pkg::CAI_ADC_W || pwdata[4:0] == cai_pkg::CAI_ADC_M)
            ? st_ff.flags[cai_pkg::CAI_F_C] : 1'b0; // RL1 RL2
      sum = {1'b0, st_ff.work} + {1'b0, opb} + {8'h00, cin};
      lsum = {1'b0, st_ff.work[3:0]} + {1'b0, opb[3:0]} + {4'h0, cin};
      ov = (st_ff.work[7] == opb[7]) && (sum[7] != opb[7]);
      // decimal fixup digits, computed from the working register
      lo_fix = (st_ff.work[3:0] > cai_pkg::CAI_DIG_LIM[3:0]) || st_ff.flags[cai_pkg::CAI_F_HC];
      lo_n = lo_fix ? st_ff.work[3:0] + cai_pkg::CAI_DIG_ADJ[3:0] : st_ff.work[3:0]; // RL10
      dc = lo_fix ? !st_ff.flags[cai_pkg::CAI_F_HC] : 1'b0; // RL10
      hi_n = {1'b0, st_ff.work[7:4]} + {4'h0, dc};
      hi_fix = (hi_n > 5'(cai_pkg::CAI_DIG_LIM)) || st_ff.flags[cai_pkg::CAI_F_C];
      res = {(hi_fix ? hi_n[3:0] + cai_pkg::CAI_DIG_ADJ[3:0] : hi_n[3:0]), lo_n}; // RL11
   end

   // ---------------------------------------------------------------------
   // next state: bus slave and one-shot execution
   // ---------------------------------------------------------------------
   always_comb begin
      logic [7:0] r;
      logic upd_z, go;
      r = 8'h00;
      upd_z = 1'b0;
      go = 1'b0;
      nxt_st = st_ff;
      nxt_st.ready = psel && penable && !st_ff.ready;
      nxt_st.err = 1'b0;
      nxt_st.rdata = 32'h0000_0000;
      // extra instruction cycle after a low pc write
      if (st_ff.wait_cnt != 4'h0) begin
         nxt_st.wait_cnt = st_ff.wait_cnt - 4'h1; // RL17
      end
      if (acc_r) begin
         unique case (paddr)
            cai_pkg::CAI_A_WORK: nxt_st.rdata = {24'h0, st_ff.work};
            cai_pkg::CAI_A_FLAG: nxt_st.rdata = {26'h0, st_ff.flags};
            cai_pkg::CAI_A_PC: nxt_st.rdata = {20'h0, st_ff.pc};
            cai_pkg::CAI_A_MEMR: nxt_st.rdata = {22'h0, st_ff.lowpc, st_ff.mwr, st_ff.mres};
            cai_pkg::CAI_A_STK: nxt_st.rdata = {19'h0, st_ff.push, st_ff.stk};
            cai_pkg::CAI_A_STAT:
               nxt_st.rdata = {28'h0, st_ff.pmask, st_ff.slp, st_ff.wait_cnt != 4'h0};
            cai_pkg::CAI_A_WDT: nxt_st.rdata = {16'h0, st_ff.pre, st_ff.wdt};
            default: nxt_st.err = 1'b1;
         endcase
      end
      if (acc_w) begin
         unique case (paddr)
            cai_pkg::CAI_A_CMD: go = 1'b1;
            cai_pkg::CAI_A_OPND: begin
               nxt_st.mem = pwdata[7:0];
               nxt_st.imm = pwdata[15:8];
               nxt_st.tgt = pwdata[27:16];
            end
            cai_pkg::CAI_A_WORK: nxt_st.work = pwdata[7:0];
            cai_pkg::CAI_A_FLAG: nxt_st.flags = pwdata[5:0];
            cai_pkg::CAI_A_PC: nxt_st.pc = pwdata[11:0];
            default: nxt_st.err = 1'b1;
         endcase
         // commands refused while asleep or during the extra cycle
         if (go && (st_ff.slp || st_ff.wait_cnt != 4'h0)) begin
            nxt_st.err = 1'b1;
            go = 1'b0;
         end
      end
      // free-running watchdog with prescaler; a sleeping core stops it
      if (!st_ff.slp) begin
         nxt_st.pre = st_ff.pre + 8'h01;
         if (st_ff.pre == 8'hFF) nxt_st.wdt = st_ff.wdt + 8'h01;
      end
      if (go) begin
         nxt_st.pc = st_ff.pc + 12'h001;
         nxt_st.lowpc = 1'b0;
         // write and push marks stand until the next command so software can read them
         nxt_st.mwr = 1'b0;
         nxt_st.push = 1'b0;
         unique case (cai_pkg::cai_op_e'(pwdata[4:0]))
            cai_pkg::CAI_ADC_W, cai_pkg::CAI_ADD_W, cai_pkg::CAI_ADD_X,
            cai_pkg::CAI_ADC_M, cai_pkg::CAI_ADD_M: begin
               // operands must be latched before the command: adder reads st_ff
               r = sum[7:0]; // RL1 RL2
               nxt_st.flags[cai_pkg::CAI_F_C] = sum[8];
               nxt_st.flags[cai_pkg::CAI_F_HC] = lsum[4];
               nxt_st.flags[cai_pkg::CAI_F_OV] = ov;
               upd_z = 1'b1;
               if (pwdata[4:0] == cai_pkg::CAI_ADC_M || pwdata[4:0] == cai_pkg::CAI_ADD_M)
                  nxt_st.mwr = 1'b1;
               else
                  nxt_st.work = r;
            end
            cai_pkg::CAI_AND_W, cai_pkg::CAI_AND_X, cai_pkg::CAI_AND_M: begin
               r = st_ff.work & (pwdata[4:0] == cai_pkg::CAI_AND_X ? st_ff.imm : st_ff.mem); // RL3
               upd_z = 1'b1;
               if (pwdata[4:0] == cai_pkg::CAI_AND_M) nxt_st.mwr = 1'b1;
               else nxt_st.work = r;
            end
            cai_pkg::CAI_CALL: begin
               nxt_st.stk = st_ff.pc + 12'h001; // RL4
               nxt_st.push = 1'b1;
               nxt_st.pc = st_ff.tgt; // RL4
            end
            cai_pkg::CAI_ZFILL: begin
               r = 8'h00; // RL5
               nxt_st.mwr = 1'b1;
            end
            cai_pkg::CAI_ZBIT: begin
               r = st_ff.mem & ~(8'h01 << pwdata[10:8]); // RL6
               nxt_st.mwr = 1'b1;
            end
            cai_pkg::CAI_KICK: begin
               nxt_st.wdt = 8'h00; // RL7
               nxt_st.pre = 8'h00;
               nxt_st.pmask = 2'b00;
               nxt_st.flags[cai_pkg::CAI_F_SL] = 1'b0;
               nxt_st.flags[cai_pkg::CAI_F_TO] = 1'b0;
            end
            cai_pkg::CAI_PRE1, cai_pkg::CAI_PRE2: begin
               // record this half; clear only once both halves have run
               if ((st_ff.pmask | (pwdata[0] ? 2'b01 : 2'b10)) == 2'b11) begin // RL8
                  nxt_st.wdt = 8'h00;
                  nxt_st.pre = 8'h00;
                  nxt_st.pmask = 2'b00;
                  nxt_st.flags[cai_pkg::CAI_F_SL] = 1'b0;
                  nxt_st.flags[cai_pkg::CAI_F_TO] = 1'b0;
               end else begin
                  nxt_st.pmask = st_ff.pmask | (pwdata[0] ? 2'b01 : 2'b10); // RL8
               end
            end
            cai_pkg::CAI_INV_M, cai_pkg::CAI_INV_W: begin
               r = ~st_ff.mem; // RL9
               upd_z = 1'b1;
               if (pwdata[4:0] == cai_pkg::CAI_INV_M) nxt_st.mwr = 1'b1;
               else nxt_st.work = r;
            end
            cai_pkg::CAI_DFIX: begin
               r = res; // RL11
               nxt_st.mwr = 1'b1;
               if (hi_fix) nxt_st.flags[cai_pkg::CAI_F_C] = 1'b1; // RL11
            end
            cai_pkg::CAI_DEC_M, cai_pkg::CAI_DEC_W: begin
               r = st_ff.mem - 8'h01; // RL12
               upd_z = 1'b1;
               if (pwdata[4:0] == cai_pkg::CAI_DEC_M) nxt_st.mwr = 1'b1;
               else nxt_st.work = r;
            end
            cai_pkg::CAI_INC_M, cai_pkg::CAI_INC_W: begin
               r = st_ff.mem + 8'h01; // RL13
               upd_z = 1'b1;
               if (pwdata[4:0] == cai_pkg::CAI_INC_M) nxt_st.mwr = 1'b1;
               else nxt_st.work = r;
            end
            cai_pkg::CAI_SLEEP: begin
               nxt_st.slp = 1'b1; // RL14
               nxt_st.wdt = 8'h00; // RL15
               nxt_st.pre = 8'h00;
               nxt_st.flags[cai_pkg::CAI_F_SL] = 1'b1;
               nxt_st.flags[cai_pkg::CAI_F_TO] = 1'b0;
            end
            cai_pkg::CAI_GOTO: nxt_st.pc = st_ff.tgt; // RL16
            default: ;
         endcase
         // flags not named above are left as they were
         if (upd_z) nxt_st.flags[cai_pkg::CAI_F_Z] = (r == 8'h00); // RL18 RL19
         nxt_st.mres = r;
         // a memory result aimed at the low pc byte costs one more cycle
         if (nxt_st.mwr && st_ff.mem == 8'h00) begin
            nxt_st.lowpc = 1'b1;
            nxt_st.wait_cnt = cai_pkg::CAI_EXTRA_CLKS; // RL17
         end
      end
      // software wakes the core by writing the program counter
      if (acc_w && paddr == cai_pkg::CAI_A_PC) nxt_st.slp = 1'b0;
      // busy is registered so the pin comes straight from a flip-flop
      nxt_st.bsy = (nxt_st.wait_cnt != 4'h0);
   end

   // ---------------------------------------------------------------------
   // state register
   // ---------------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st_ff <= '0;
      end else begin
         st_ff <= nxt_st;
      end
   end

   assign prdata = st_ff.rdata;
   assign pready = st_ff.ready;
   assign pslverr = st_ff.err;
   assign asleep = st_ff.slp;
   assign busy = st_ff.bsy;

   // ---------------------------------------------------------------------
   // checks
   // ---------------------------------------------------------------------
   sleep_flags_a: assert property (@(posedge pclk) disable iff (!presetn) // RL15
      $rose(st_ff.slp) |-> st_ff.flags[cai_pkg::CAI_F_SL] && !st_ff.flags[cai_pkg::CAI_F_TO]
         && st_ff.wdt == 8'h00) else $error("sleep entry flags wrong");
   zero_track_a: assert property (@(posedge pclk) disable iff (!presetn) // RL19
      $past(acc_w && paddr == cai_pkg::CAI_A_CMD && pwdata[4:0] == cai_pkg::CAI_DEC_M
         && !st_ff.slp && !busy) && st_ff.mwr
         |-> st_ff.flags[cai_pkg::CAI_F_Z] == (st_ff.mres == 8'h00))
      else $error("zero flag mismatch");
   extra_cyc_a: assert property (@(posedge pclk) disable iff (!presetn) // RL17
      st_ff.lowpc && $rose(busy) |-> busy [*4] ##1 !busy) else $error("extra cycle length wrong");
   call_push_a: assert property (@(posedge pclk) disable iff (!presetn) // RL4
      $rose(st_ff.push) |-> st_ff.stk == $past(st_ff.pc) + 12'h001
         && st_ff.pc == $past(st_ff.tgt))
      else $error("call push wrong");
   flags_hold_a: assert property (@(posedge pclk) disable iff (!presetn) // RL18
      $rose(st_ff.push) |-> st_ff.flags == $past(st_ff.flags)) else $error("call changed flags");
   zfill_val_a: assert property (@(posedge pclk) disable iff (!presetn) // RL5
      $past(acc_w && paddr == cai_pkg::CAI_A_CMD && pwdata[4:0] == cai_pkg::CAI_ZFILL
         && !st_ff.slp && !busy) |-> st_ff.mwr && st_ff.mres == 8'h00)
      else $error("clear byte wrong");
   ready_one_a: assert property (@(posedge pclk) disable iff (!presetn)
      pready |=> !pready) else $error("ready held too long");
   sleep_hold_a: assert property (@(posedge pclk) disable iff (!presetn) // RL14
      asleep && !(acc_w && paddr == cai_pkg::CAI_A_PC) |=> asleep && $stable(st_ff.wdt))
      else $error("sleep not held");
   cov_call_c: cover property (@(posedge pclk) st_ff.push);
   cov_sleep_c: cover property (@(posedge pclk) $rose(asleep));
   cov_busy_c: cover property (@(posedge pclk) $rose(busy));
endmodule
`default_nettype wire

// [test/cai_mem_model.sv]
// cai_mem_model: small data memory that stands behind the datapath's operand port
// assumes: the bench loads operand bytes here and writes memory-destination results back
`timescale 1ns/10ps
`default_nettype none
module cai_mem_model (
   input wire logic clk,
   input wire logic we,
   input wire logic [3:0] addr,
   input wire logic [7:0] wdata,
   output logic [7:0] rdata
);
   logic [7:0] mem [16];
   // asynchronous read, so an operand is ready as soon as its slot is chosen
   assign rdata = mem[addr];
   // -----------------------------------------------------------------
   // write port: one byte per strobed edge
   // -----------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (we) begin
         mem[addr] <= wdata;
      end
   end
endmodule
`default_nettype wire

// [test/core_alu_instruction_semantics_bench.sv]
// core_alu_instruction_semantics_bench: directed apb tests of the execution datapath
// assumes: cai_core answers each apb access with a registered one-cycle pready
`timescale 1ns/10ps
`default_nettype none
module core_alu_instruction_semantics_bench;
   typedef struct packed {
      cai_pkg::cai_op_e op;
      logic [2:0] bs;
      logic [7:0] w;
      logic [7:0] m;
      logic [7:0] imm;
      logic [5:0] fi;
      logic [7:0] res;
      logic dm;
      logic [5:0] fo;
   } cai_case_s;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata;
   logic pready, pslverr, asleep, busy;
   logic m_we = 1'b0;
   logic [3:0] m_addr = 4'h0;
   logic [7:0] m_wdata = 8'h00;
   logic [7:0] m_rdata;
   int bad_count = 0;
   int n_checks = 0;
   int k;
   // op, bit, work, mem, imm, flags in, result, to memory, flags out
   cai_case_s tbl [19] = '{
      '{cai_pkg::CAI_ADD_X, 3'h0, 8'h7F, 8'h11, 8'h01, 6'h00, 8'h80, 1'b0, 6'h0A},
      '{cai_pkg::CAI_ADC_M, 3'h0, 8'hFE, 8'h01, 8'h00, 6'h01, 8'h00, 1'b1, 6'h07},
      '{cai_pkg::CAI_ADD_W, 3'h0, 8'h80, 8'h80, 8'h00, 6'h00, 8'h00, 1'b0, 6'h0D},
      '{cai_pkg::CAI_ADC_W, 3'h0, 8'h0E, 8'h01, 8'h00, 6'h01, 8'h10, 1'b0, 6'h02},
      '{cai_pkg::CAI_ADD_M, 3'h0, 8'h01, 8'h02, 8'h00, 6'h30, 8'h03, 1'b1, 6'h30},
      '{cai_pkg::CAI_AND_W, 3'h0, 8'hF0, 8'h0F, 8'h00, 6'h09, 8'h00, 1'b0, 6'h0D},
      '{cai_pkg::CAI_AND_X, 3'h0, 8'hF0, 8'h11, 8'h3C, 6'h0F, 8'h30, 1'b0, 6'h0B},
      '{cai_pkg::CAI_AND_M, 3'h0, 8'h0F, 8'hF0, 8'h00, 6'h03, 8'h00, 1'b1, 6'h07},
      '{cai_pkg::CAI_INV_M, 3'h0, 8'h00, 8'hFF, 8'h00, 6'h00, 8'h00, 1'b1, 6'h04},
      '{cai_pkg::CAI_INV_W, 3'h0, 8'h00, 8'h5A, 8'h00, 6'h04, 8'hA5, 1'b0, 6'h00},
      '{cai_pkg::CAI_INC_W, 3'h0, 8'h00, 8'hFF, 8'h00, 6'h00, 8'h00, 1'b0, 6'h04},
      '{cai_pkg::CAI_INC_M, 3'h0, 8'h00, 8'h10, 8'h00, 6'h04, 8'h11, 1'b1, 6'h00},
      '{cai_pkg::CAI_DEC_M, 3'h0, 8'h00, 8'h01, 8'h00, 6'h0B, 8'h00, 1'b1, 6'h0F},
      '{cai_pkg::CAI_DEC_W, 3'h0, 8'h00, 8'h80, 8'h00, 6'h04, 8'h7F, 1'b0, 6'h00},
      '{cai_pkg::CAI_ZFILL, 3'h0, 8'h00, 8'h5A, 8'h00, 6'h3F, 8'h00, 1'b1, 6'h3F},
      '{cai_pkg::CAI_ZBIT, 3'h3, 8'h00, 8'hFF, 8'h00, 6'h15, 8'hF7, 1'b1, 6'h15},
      '{cai_pkg::CAI_DFIX, 3'h0, 8'h9A, 8'h11, 8'h00, 6'h00, 8'h00, 1'b1, 6'h01},
      '{cai_pkg::CAI_DFIX, 3'h0, 8'h45, 8'h11, 8'h00, 6'h02, 8'h4B, 1'b1, 6'h02},
      '{cai_pkg::CAI_DFIX, 3'h0, 8'h23, 8'h11, 8'h00, 6'h01, 8'h83, 1'b1, 6'h01}};

   always #50 pclk = ~pclk;

   cai_core cai_core_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .asleep(asleep), .busy(busy));
   cai_mem_model cai_mem_model_i (.clk(pclk), .we(m_we), .addr(m_addr), .wdata(m_wdata),
      .rdata(m_rdata));

   // -----------------------------------------------------------------
   // reporting
   // -----------------------------------------------------------------
   task automatic print_verdict();
      $display("checks %0d, mismatches %0d", n_checks, bad_count);
      if (bad_count == 0 && n_checks > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp) begin
         bad_count++;
         $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   // -----------------------------------------------------------------
   // apb master: request held until pready is sampled high
   // -----------------------------------------------------------------
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
         output logic [31:0] r, output logic err);
      int i;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      for (i = 0; i < 20; i++) begin
         @(posedge pclk);
         if (pready === 1'b1) break;
      end
      r = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (i == 20) begin
         bad_count++;
         print_verdict();
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic e);
      logic [31:0] r;
      logic er;
      apb(1'b1, a, d, r, er);
      chk({31'h0, er}, {31'h0, e});
   endtask

   task automatic rdc(input logic [7:0] a, input logic [31:0] mask, input logic [31:0] exp);
      logic [31:0] r;
      logic er;
      apb(1'b0, a, 32'h0, r, er);
      chk(r & mask, exp);
   endtask

   // operand comes from the memory model; a memory result is written back into it
   task automatic do_op(input cai_pkg::cai_op_e op, input logic [2:0] bs, input logic [3:0] s,
         input logic [7:0] imm, input logic [11:0] tgt);
      logic [31:0] r;
      logic er;
      @(posedge pclk);
      m_addr <= s;
      @(posedge pclk);
      wr(cai_pkg::CAI_A_OPND, {4'h0, tgt, imm, m_rdata}, 1'b0);
      wr(cai_pkg::CAI_A_CMD, {21'h0, bs, 3'h0, op}, 1'b0);
      apb(1'b0, cai_pkg::CAI_A_MEMR, 32'h0, r, er);
      if (r[8] === 1'b1) begin
         m_we <= 1'b1;
         m_wdata <= r[7:0];
         @(posedge pclk);
         m_we <= 1'b0;
         // let the stored byte settle before anyone reads it back
         @(posedge pclk);
      end
   endtask

   task automatic setwf(input logic [7:0] w, input logic [5:0] f);
      wr(cai_pkg::CAI_A_WORK, {24'h0, w}, 1'b0);
      wr(cai_pkg::CAI_A_FLAG, {26'h0, f}, 1'b0);
   endtask

   task automatic put(input logic [3:0] s, input logic [7:0] d);
      @(posedge pclk);
      m_we <= 1'b1;
      m_addr <= s;
      m_wdata <= d;
      @(posedge pclk);
      m_we <= 1'b0;
   endtask

   // -----------------------------------------------------------------
   // main sequence
   // -----------------------------------------------------------------
   initial begin
      repeat (4) @(posedge pclk);
      presetn <= 1'b1;
      rdc(cai_pkg::CAI_A_FLAG, 32'h3F, {26'h0, cai_pkg::CAI_FLAG_RST});
      // arithmetic, logic, invert, step and fixup cases share one loop
      for (k = 0; k < 19; k++) begin
         put(k[3:0], tbl[k].m);
         setwf(tbl[k].w, tbl[k].fi);
         do_op(tbl[k].op, tbl[k].bs, k[3:0], tbl[k].imm, 12'h000);
         if (tbl[k].dm) begin
            chk({24'h0, m_rdata}, {24'h0, tbl[k].res});
         end else begin
            rdc(cai_pkg::CAI_A_WORK, 32'hFF, {24'h0, tbl[k].res});
         end
         rdc(cai_pkg::CAI_A_FLAG, 32'h3F, {26'h0, tbl[k].fo});
         rdc(cai_pkg::CAI_A_MEMR, 32'h100, {23'h0, tbl[k].dm, 8'h00});
      end
      // call pushes the next address, jump loads its target and keeps the flags
      wr(cai_pkg::CAI_A_PC, 32'h123, 1'b0);
      do_op(cai_pkg::CAI_CALL, 3'h0, 4'h1, 8'h00, 12'h456);
      rdc(cai_pkg::CAI_A_PC, 32'hFFF, 32'h456);
      rdc(cai_pkg::CAI_A_STK, 32'h1FFF, 32'h1124);
      do_op(cai_pkg::CAI_GOTO, 3'h0, 4'h1, 8'h00, 12'h0AB);
      rdc(cai_pkg::CAI_A_PC, 32'hFFF, 32'h0AB);
      rdc(cai_pkg::CAI_A_FLAG, 32'h3F, 32'h01);
      // single kick, then the two-step kick with a repeated first half
      setwf(8'h00, 6'h30);
      do_op(cai_pkg::CAI_KICK, 3'h0, 4'h1, 8'h00, 12'h000);
      rdc(cai_pkg::CAI_A_FLAG, 32'h3F, 32'h00);
      rdc(cai_pkg::CAI_A_WDT, 32'hFF, 32'h00);
      setwf(8'h00, 6'h30);
      do_op(cai_pkg::CAI_PRE1, 3'h0, 4'h1, 8'h00, 12'h000);
      do_op(cai_pkg::CAI_PRE1, 3'h0, 4'h1, 8'h00, 12'h000);
      rdc(cai_pkg::CAI_A_FLAG, 32'h3F, 32'h30);
      do_op(cai_pkg::CAI_PRE2, 3'h0, 4'h1, 8'h00, 12'h000);
      rdc(cai_pkg::CAI_A_FLAG, 32'h3F, 32'h00);
      // sleep: flags, pc step, refusal of further commands, wake by pc write
      wr(cai_pkg::CAI_A_PC, 32'h0FF, 1'b0);
      setwf(8'h66, 6'h21);
      do_op(cai_pkg::CAI_SLEEP, 3'h0, 4'h1, 8'h00, 12'h000);
      chk({31'h0, asleep}, 32'h1);
      rdc(cai_pkg::CAI_A_FLAG, 32'h3F, 32'h11);
      rdc(cai_pkg::CAI_A_PC, 32'hFFF, 32'h100);
      rdc(cai_pkg::CAI_A_WDT, 32'hFFFF, 32'h0);
      wr(cai_pkg::CAI_A_CMD, {27'h0, cai_pkg::CAI_INC_W}, 1'b1);
      rdc(cai_pkg::CAI_A_WORK, 32'hFF, 32'h66);
      wr(cai_pkg::CAI_A_PC, 32'h200, 1'b0);
      #1;
      chk({31'h0, asleep}, 32'h0);
      wr(8'h24, 32'h0, 1'b1);
      // a result aimed at the low pc byte costs one extra instruction cycle
      wr(cai_pkg::CAI_A_OPND, 32'h0, 1'b0);
      wr(cai_pkg::CAI_A_CMD, {27'h0, cai_pkg::CAI_ZFILL}, 1'b0);
      #1;
      chk({31'h0, busy}, 32'h1);
      for (k = 0; k < 9 && busy === 1'b1; k++) begin
         @(posedge pclk);
         #1;
      end
      chk({31'h0, busy}, 32'h0);
      chk(k, cai_pkg::CAI_CYC_CLKS - 1);
      rdc(cai_pkg::CAI_A_MEMR, 32'h200, 32'h200);
      print_verdict();
   end
endmodule
`default_nettype wire
